/* sdlc_device.sv */
// Converter end: shift register, input and output registers, clear and power-down priority
`include "sdlc_params.svh"
module sdlc_device (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Link pins
    sdlc_link_if.device link,
    // Converter side
    output logic [15:0] dac_code,
    output logic [15:0] input_code,
    output logic out_at_zero,
    output logic out_powered_down
);
    logic sclk_s, frame_s, sdi_s, load_s, clr_s, pd_s;
    logic [5:0] pins_raw, pins_s;
    assign pins_raw = {link.sclk, link.frame_n, link.serial_data_in, link.load_output_n,
        link.clear_output_n, link.power_down_n};
    // One synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            sdlc_sync #(.INIT(gi == 3 ? 1'b0 : 1'b1)) i_sdlc_sync (
                .mclk(mclk),
                .srst(srst),
                .pin(pins_raw[gi]),
                .level(pins_s[gi])
            );
        end
    endgenerate
    assign {sclk_s, frame_s, sdi_s, load_s, clr_s, pd_s} = pins_s;

    typedef struct packed {
        logic sclk_p;
        logic frame_p;
        logic load_p;
        logic [15:0] shift;
        logic [15:0] in_reg;
        logic [15:0] out_reg;
        logic [4:0] count;
        logic zero_hold;
        logic sdo_bit;
    } sdlc_dev_st_t;
    sdlc_dev_st_t st_q, st_d;

    logic fall_sclk, rise_frame, fall_load, load_now;
    always_comb begin
        fall_sclk = st_q.sclk_p & ~sclk_s;
        rise_frame = ~st_q.frame_p & frame_s;
        fall_load = st_q.load_p & ~load_s;
        load_now = 1'b0;
        st_d = st_q;
        st_d.sclk_p = sclk_s;
        st_d.frame_p = frame_s;
        st_d.load_p = load_s;
        // Frame start: shift register takes output register for readback
        if (!frame_s && st_q.frame_p) begin
            st_d.shift = st_q.out_reg;
            st_d.count = 5'h00;
            st_d.sdo_bit = st_q.out_reg[15];
        end
        if (!frame_s && fall_sclk) begin
            st_d.shift = {st_q.shift[14:0], sdi_s};
            st_d.sdo_bit = st_q.shift[14];
            if (st_q.count != 5'h10) begin
                st_d.count = st_q.count + 5'h01;
            end
        end
        // Word complete: input register takes the low 16 bits
        if (rise_frame && st_q.count != 5'h00) begin
            st_d.in_reg = st_q.shift;
            if (!load_s) begin
                load_now = 1'b1;
            end
        end
        // Asynchronous update mode, only with frame high
        if (fall_load && frame_s) begin
            load_now = 1'b1;
        end
        if (load_now) begin
            st_d.out_reg = rise_frame ? st_q.shift : st_q.in_reg;
            st_d.zero_hold = ~clr_s;
        end
        // Clear pins the output to zero until the next load
        if (!clr_s) begin
            st_d.zero_hold = 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            // Power-up: midscale everywhere, output at ground
            st_q <= '{1'b1, 1'b1, 1'b1, `SDLC_MIDSCALE, `SDLC_MIDSCALE, `SDLC_MIDSCALE, 5'h00, 1'b1, 1'b1};
        end else begin
            st_q <= st_d;
        end
    end
    // Zero code is midscale in straight binary
    assign dac_code = (st_q.zero_hold || !pd_s) ? `SDLC_ZERO_CODE : st_q.out_reg;
    assign input_code = st_q.in_reg;
    assign out_at_zero = st_q.zero_hold | ~pd_s;
    assign out_powered_down = ~pd_s;
    // Open drain: pull down for zero, released in power-down
    assign link.sdo_pull_en = ~st_q.sdo_bit & pd_s;
endmodule : sdlc_device

/* sdlc_params.svh */
// Constants shared by both ends of the serial converter load control
// What this block does
// - Code is straight binary, 0x8000 gives zero
// - Clear low forces output to zero
// - After clear, zero holds until load-output low
// - Power-down overrides all; registers stay writable
// - Clear low, load low: both registers written, zero
// - Clear low, load high: input register only
// - Normal, load low: both written, output follows
// - All high: input register only, output unchanged
// - No pull-down drive during power-down
// - Output at ground during power-up and power-down
// - Serial output is shift register end
// - Host sends sixteen times N clocks
// - Last device's word is shifted first
// - Host raises frame select after all words
// - Continuous or burst clock both allowed
// - Shared load-output pulse updates all devices
// - Frame low shifts output register out
// - After sixteen edges output echoes input delayed
// - Readback keeps load-output high all frame
// - Shift on falling clock while frame low
// - Power-up loads midscale into both registers
// - Load low during frame: update at frame end
// - Load high: update at load-output falling edge
`ifndef SDLC_PARAMS_SVH
`define SDLC_PARAMS_SVH
`define SDLC_WORD_BITS 16
`define SDLC_MIDSCALE 16'h8000
`define SDLC_ZERO_CODE 16'h8000
`define SDLC_MCLK_HZ 100000000
`define SDLC_SCLK_PERIOD_NS 160
`define SDLC_SCLK_HALF_CYCLES ((`SDLC_SCLK_PERIOD_NS * (`SDLC_MCLK_HZ / 1000000)) / 2000)
`endif

/* sdlc_pkg.sv */
// Types used by the host end of the serial converter load control
package sdlc_pkg;
    typedef logic [15:0] sdlc_word_t;
    typedef enum logic [1:0] {SDLC_IDLE, SDLC_SHIFT, SDLC_GAP} sdlc_state_t;
endpackage : sdlc_pkg

/* sdlc_link_if.sv */
// Pins between host controller and converter
interface sdlc_link_if;
    logic sclk;
    logic frame_n;
    logic serial_data_in;
    logic load_output_n;
    logic clear_output_n;
    logic power_down_n;
    logic sdo_pull_en;
    wire serial_data_out;
    // Open drain with external pull-up
    assign serial_data_out = sdo_pull_en ? 1'b0 : 1'b1;
    modport device (input sclk, frame_n, serial_data_in, load_output_n, clear_output_n, power_down_n,
        output sdo_pull_en);
    modport host (output sclk, frame_n, serial_data_in, load_output_n, clear_output_n, power_down_n,
        input serial_data_out);
endinterface : sdlc_link_if

/* sdlc_sync.sv */
// Three-stage synchroniser with agreement filter for one pin
module sdlc_sync #(
    parameter logic INIT = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Pin and filtered level
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sdlc_sync_st_t;
    sdlc_sync_st_t st_q, st_d;
    // Level changes only when the last two stages agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q <= '{INIT, INIT, INIT, INIT};
        end else begin
            st_q <= st_d;
        end
    end
    assign level = st_q.lvl;
endmodule : sdlc_sync

/* sdlc_host.sv */
// Host end: sends a chain of words, divides the shift clock, drives control pins
`include "sdlc_params.svh"
module sdlc_host #(
    parameter int CHAIN = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Link pins
    sdlc_link_if.host link,
    // User request: words, last device's word at the top
    input wire logic start,
    input wire logic [16*CHAIN-1:0] words,
    input wire logic sync_load,
    output logic busy,
    output logic [16*CHAIN-1:0] readback,
    // Control levels
    input wire logic load_pulse,
    input wire logic clear_req,
    input wire logic power_down_req
);
    localparam int HALF = `SDLC_SCLK_HALF_CYCLES;
    localparam int NBITS = 16 * CHAIN;
    typedef struct packed {
        sdlc_pkg::sdlc_state_t state;
        logic [15:0] div;
        logic [15:0] bits;
        logic sclk;
        logic frame_n;
        logic load_n;
        logic [16*CHAIN-1:0] tx;
        logic [16*CHAIN-1:0] rx;
    } sdlc_host_st_t;
    sdlc_host_st_t st_q, st_d;
    always_comb begin
        st_d = st_q;
        st_d.load_n = ~load_pulse;
        case (st_q.state)
            sdlc_pkg::SDLC_IDLE: begin
                if (start) begin
                    st_d.state = sdlc_pkg::SDLC_SHIFT;
                    st_d.tx = words;
                    st_d.frame_n = 1'b0;
                    st_d.bits = 16'h0000;
                    st_d.div = 16'h0000;
                    st_d.load_n = ~sync_load;
                end
            end
            sdlc_pkg::SDLC_SHIFT: begin
                st_d.load_n = st_q.load_n;
                st_d.div = st_q.div + 16'h0001;
                if (st_q.div == 16'(HALF - 1)) begin
                    st_d.div = 16'h0000;
                    st_d.sclk = ~st_q.sclk;
                    // Falling edge: device samples data, we sample readback
                    if (st_q.sclk) begin
                        st_d.rx = {st_q.rx[NBITS-2:0], link.serial_data_out};
                        st_d.bits = st_q.bits + 16'h0001;
                        if (st_q.bits == 16'(NBITS - 1)) begin
                            st_d.state = sdlc_pkg::SDLC_GAP;
                        end
                    end else begin
                        // Rising edge: next bit, so it stands a full half period before the device samples
                        st_d.tx = {st_q.tx[NBITS-2:0], 1'b0};
                    end
                end
            end
            sdlc_pkg::SDLC_GAP: begin
                st_d.load_n = st_q.load_n;
                st_d.div = st_q.div + 16'h0001;
                if (st_q.div == 16'(HALF - 1)) begin
                    // Clock returns to idle high with the frame; the load level is kept one more
                    // cycle so the device still sees it low when the frame closes
                    st_d.sclk = 1'b1;
                    st_d.frame_n = 1'b1;
                    st_d.state = sdlc_pkg::SDLC_IDLE;
                end
            end
            default: st_d.state = sdlc_pkg::SDLC_IDLE;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q <= '{sdlc_pkg::SDLC_IDLE, 16'h0000, 16'h0000, 1'b1, 1'b1, 1'b1, '0, '0};
        end else begin
            st_q <= st_d;
        end
    end
    assign link.sclk = st_q.sclk;
    assign link.frame_n = st_q.frame_n;
    assign link.serial_data_in = st_q.tx[NBITS-1];
    assign link.load_output_n = st_q.load_n;
    assign link.clear_output_n = ~clear_req;
    assign link.power_down_n = ~power_down_req;
    assign busy = st_q.state != sdlc_pkg::SDLC_IDLE;
    assign readback = st_q.rx;
endmodule : sdlc_host

/* sdlc_link_monitor.sv */
// Checker watching the link pins between host and converter
module sdlc_link_monitor #(
    parameter int CHAIN = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Host driven pins
    input wire logic sclk,
    input wire logic frame_n,
    input wire logic serial_data_in,
    input wire logic load_output_n,
    input wire logic clear_output_n,
    input wire logic power_down_n,
    // Converter pull-down and resolved line
    input wire logic sdo_pull_en,
    input wire logic serial_data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] falls_q;

    default clocking mon_cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    // Falling shift edges in the current frame
    always_ff @(posedge mclk) begin
        if (srst || frame_n) begin
            falls_q <= 8'h00;
        end else if ($fell(sclk)) begin
            falls_q <= falls_q + 8'h01;
        end
    end

    AST_SCLK_IDLE: assert property (frame_n |-> sclk) else $error("shift clock low outside frame");
    AST_HALF_PERIOD: assert property ($fell(sclk) |-> !sclk[*8] ##1 sclk) else $error("bad half period");
    AST_FIRST_FALL: assert property ($fell(frame_n) |-> ##[1:16] $fell(sclk)) else $error("no shift edge");
    AST_EDGE_COUNT: assert property ($rose(frame_n) |-> falls_q == 16 * CHAIN) else $error("wrong edge count");
    AST_FRAME_CLOSE: assert property ($fell(sclk) && falls_q == 16 * CHAIN - 1 |-> ##[8:24] $rose(frame_n))
        else $error("frame not closed");
    AST_DATA_HELD: assert property ($fell(sclk) |-> $stable(serial_data_in)) else $error("data moved at edge");
    AST_LOAD_HELD: assert property (!frame_n && !$past(frame_n) |-> $stable(load_output_n))
        else $error("load moved in frame");
    AST_PD_RELEASE: assert property (!power_down_n[*6] |-> !sdo_pull_en) else $error("pull-down in power-down");
    AST_SDO_QUIET: assert property ((frame_n && power_down_n)[*8] |=> $stable(sdo_pull_en))
        else $error("serial out moved idle");

    // Main scenarios reached
    cover property ($rose(frame_n) && !load_output_n);
    cover property ($rose(frame_n) && !power_down_n);
    cover property ($rose(frame_n) && !clear_output_n);
    cover property ($rose(frame_n) && !serial_data_out);
endmodule : sdlc_link_monitor

/* serial_dac_load_control_bench.sv */
// Bench joining host end and converter end over one link
module serial_dac_load_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, srst, start, sync_load, busy, load_pulse, clear_req, power_down_req;
    logic out_at_zero, out_powered_down;
    logic [15:0] words, readback, dac_code, input_code;
    int miscompares, total_checks;

    sdlc_link_if link();
    sdlc_host #(.CHAIN(1)) i_sdlc_host(.mclk, .srst, .link(link.host), .start, .words, .sync_load, .busy,
        .readback, .load_pulse, .clear_req, .power_down_req);
    sdlc_device i_sdlc_device(.mclk, .srst, .link(link.device), .dac_code, .input_code, .out_at_zero,
        .out_powered_down);
    sdlc_link_monitor #(.CHAIN(1)) i_sdlc_link_monitor(.mclk(mclk), .srst(srst), .sclk(link.sclk),
        .frame_n(link.frame_n), .serial_data_in(link.serial_data_in), .load_output_n(link.load_output_n),
        .clear_output_n(link.clear_output_n), .power_down_n(link.power_down_n),
        .sdo_pull_en(link.sdo_pull_en), .serial_data_out(link.serial_data_out));

    // Free running 100 MHz clock
    always #5 mclk = ~mclk;

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask : settle

    // One frame; pins pass a filter, so wait past it afterwards
    task automatic send(input logic [15:0] w, input logic s);
        int n;
        n = 0;
        words <= w;
        sync_load <= s;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        do begin
            @(negedge mclk);
            n++;
        end while (busy !== 1'b0 && n < 2000);
        if (n >= 2000) begin
            miscompares++;
            tally_and_finish();
        end else begin
            settle(8);
        end
    endtask : send

    task automatic pulse_load();
        load_pulse <= 1'b1;
        settle(6);
        load_pulse <= 1'b0;
        settle(10);
    endtask : pulse_load

    task automatic t_sync_async();
        send(16'h1234, 1'b1);
        chk("input", input_code, 16'h1234);
        chk("dac", dac_code, 16'h1234);
        chk("zero", out_at_zero, 16'h0000);
        chk("readback", readback, 16'h8000);
        chk("echo", link.serial_data_out, 16'h0000);
        send(16'habcd, 1'b0);
        chk("input", input_code, 16'habcd);
        chk("echo", link.serial_data_out, 16'h0001);
        chk("dac", dac_code, 16'h1234);
        chk("readback", readback, 16'h1234);
        pulse_load();
        chk("dac", dac_code, 16'habcd);
        $display("test load modes done");
    endtask : t_sync_async

    task automatic t_clear();
        clear_req <= 1'b1;
        settle(10);
        chk("dac", dac_code, 16'h8000);
        chk("zero", out_at_zero, 16'h0001);
        send(16'h4444, 1'b0);
        chk("input", input_code, 16'h4444);
        send(16'h5555, 1'b1);
        chk("readback", readback, 16'habcd);
        chk("dac", dac_code, 16'h8000);
        clear_req <= 1'b0;
        settle(10);
        chk("dac", dac_code, 16'h8000);
        send(16'h7777, 1'b0);
        chk("readback", readback, 16'h5555);
        pulse_load();
        chk("dac", dac_code, 16'h7777);
        $display("test clear done");
    endtask : t_clear

    task automatic t_power_down();
        power_down_req <= 1'b1;
        settle(10);
        chk("powered down", out_powered_down, 16'h0001);
        chk("dac", dac_code, 16'h8000);
        chk("sdo", link.serial_data_out, 16'h0001);
        send(16'h2222, 1'b1);
        chk("input", input_code, 16'h2222);
        chk("readback", readback, 16'hffff);
        power_down_req <= 1'b0;
        settle(10);
        chk("dac", dac_code, 16'h2222);
        send(16'h3333, 1'b0);
        chk("readback", readback, 16'h2222);
        $display("test power down done");
    endtask : t_power_down

    // Reset, then each scenario in turn
    initial begin
        mclk = 1'b0;
        srst = 1'b1;
        start = 1'b0;
        words = 16'h0000;
        sync_load = 1'b0;
        load_pulse = 1'b0;
        clear_req = 1'b0;
        power_down_req = 1'b0;
        miscompares = 0;
        total_checks = 0;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        settle(8);
        chk("dac", dac_code, 16'h8000);
        chk("input", input_code, 16'h8000);
        chk("zero", out_at_zero, 16'h0001);
        $display("test power up done");
        t_sync_async();
        t_clear();
        t_power_down();
        tally_and_finish();
    end
endmodule : serial_dac_load_control_bench
